// ---- inc/rdc_pkg.sv ----
// Constants for the reader receive signal configuration block.
// Assumes a 32-bit classic Wishbone slave bus on the system clock.
package rdc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  RDC_CFG_OFFSET  = 8'h1C; // Configuration register
	localparam logic [7:0]  RDC_STAT_OFFSET = 8'h20; // Effective state readback
	localparam int          RDC_ADDR_W      = 8;

	// ----------------------------------------------------------------
	// Field positions in the configuration register
	// ----------------------------------------------------------------
	localparam int RDC_IQ_LSB      = 21; // 3 bits, 23:21
	localparam int RDC_TEST_BIT    = 20;
	localparam int RDC_RESYNC_BIT  = 19;
	localparam int RDC_CLEAR_BIT   = 18;
	localparam int RDC_FILTOFF_BIT = 17;
	localparam int RDC_EARLY_BIT   = 16;
	localparam int RDC_SUBTH_LSB   = 12; // 4 bits, 15:12
	localparam int RDC_PHTH_LSB    = 8;  // 4 bits, 11:8
	localparam int RDC_SHORT_BIT   = 7;
	localparam int RDC_COLL_LSB    = 5;  // 2 bits, 6:5
	localparam int RDC_PSK_BIT     = 0;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [2:0] RDC_IQ_RST      = 3'h0;
	localparam logic       RDC_TEST_RST    = 1'b0;
	localparam logic       RDC_RESYNC_RST  = 1'b1;
	localparam logic       RDC_CLEAR_RST   = 1'b0;
	localparam logic       RDC_FILTOFF_RST = 1'b0;
	localparam logic       RDC_EARLY_RST   = 1'b0;
	localparam logic [3:0] RDC_SUBTH_RST   = 4'h0;
	localparam logic [3:0] RDC_PHTH_RST    = 4'h0;
	localparam logic [1:0] RDC_COLL_RST    = 2'h0;
	localparam logic       RDC_PSK_RST     = 1'b0;

	// ----------------------------------------------------------------
	// Channel select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] RDC_IQ_BOTH     = 3'h0;
	localparam logic [2:0] RDC_IQ_I_ONLY   = 3'h1;
	localparam logic [2:0] RDC_IQ_Q_ONLY   = 3'h2;
	localparam logic [2:0] RDC_IQ_STRONG   = 3'h4;
	localparam logic [2:0] RDC_IQ_FIRST    = 3'h5;

	// ----------------------------------------------------------------
	// Collision levels: shift of peak strength (1/8, 1/4, 1/2)
	// ----------------------------------------------------------------
	localparam logic [1:0] RDC_COLL_12P5   = 2'h0;
	localparam logic [1:0] RDC_COLL_25     = 2'h1;
	localparam logic [1:0] RDC_COLL_50     = 2'h2;
	localparam logic [1:0] RDC_COLL_NONE   = 2'h3;
	localparam int         RDC_SHIFT_12P5  = 3;
	localparam int         RDC_SHIFT_25    = 2;
	localparam int         RDC_SHIFT_50    = 1;

	// Relative table change: sign bit plus two magnitude bits
	localparam int         RDC_DELTA_W     = 3;
	localparam logic [3:0] RDC_THR_MAX     = 4'hF;
endpackage : rdc_pkg

// ---- hdl/rdc_thr_adjust.sv ----
// Threshold adjust: applies a sign-magnitude relative change to a
// 4-bit threshold. Assumes the delta is valid only with adj_valid.
`timescale 1ns/1ps
module rdc_thr_adjust
	import rdc_pkg::*;
(
	// Current value and relative change
	input  wire logic [3:0]             base,
	input  wire logic [RDC_DELTA_W-1:0] delta,
	// Adjusted value
	output logic      [3:0]             result
);
	// ----------------------------------------------------------------
	// Saturating add; wrap would flip a high threshold to near zero
	// ----------------------------------------------------------------
	logic [4:0] mag;
	logic [4:0] sum;
	always_comb begin
		mag = {3'h0, delta[1:0]};
		sum = {1'b0, base};
		if (delta[2]) begin
			result = (sum < mag) ? 4'h0 : 4'(sum - mag);
		end else begin
			result = ((sum + mag) > {1'b0, RDC_THR_MAX}) ? RDC_THR_MAX : 4'(sum + mag);
		end
	end
endmodule : rdc_thr_adjust

// ---- hdl/rdc_chan_sel.sv ----
// IQ channel selection for phase-shift reception.
// Assumes samples arrive on clk_sys with sample_valid.
`timescale 1ns/1ps
module rdc_chan_sel
	import rdc_pkg::*;
#(
	parameter int SW = 12
) (
	// Clock, reset, enable
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          ce,
	// Control
	input  wire logic [2:0]    sel,
	input  wire logic [3:0]    first_thr,
	input  wire logic          frame_start,
	// Samples
	input  wire logic          sample_valid,
	input  wire logic [SW-1:0] i_sample,
	input  wire logic [SW-1:0] q_sample,
	// Result
	output logic      [SW-1:0] chan_out,
	output logic               sel_reserved
);
	// ----------------------------------------------------------------
	// Magnitude of a signed sample
	// ----------------------------------------------------------------
	function automatic logic [SW-1:0] rdc_abs(input logic [SW-1:0] v);
		rdc_abs = v[SW-1] ? SW'(-v) : v;
	endfunction : rdc_abs

	logic [SW-1:0] out_q, out_d;
	logic          locked_q, locked_d, useq_q, useq_d;
	logic [SW:0]   both_sum;

	// ----------------------------------------------------------------
	// First channel locks to whichever crosses threshold first
	// ----------------------------------------------------------------
	always_comb begin
		locked_d = locked_q;
		useq_d   = useq_q;
		out_d    = out_q;
		both_sum = {i_sample[SW-1], i_sample} + {q_sample[SW-1], q_sample};
		if (frame_start) begin
			locked_d = 1'b0;
		end else if (sample_valid && !locked_q) begin
			if (rdc_abs(i_sample) > SW'(first_thr)) begin
				locked_d = 1'b1;
				useq_d   = 1'b0;
			end else if (rdc_abs(q_sample) > SW'(first_thr)) begin
				locked_d = 1'b1;
				useq_d   = 1'b1;
			end
		end
		if (sample_valid) begin
			case (sel)
				RDC_IQ_BOTH:   out_d = both_sum[SW:1];
				RDC_IQ_I_ONLY: out_d = i_sample;
				RDC_IQ_Q_ONLY: out_d = q_sample;
				RDC_IQ_STRONG: out_d = (rdc_abs(q_sample) > rdc_abs(i_sample)) ? q_sample : i_sample;
				RDC_IQ_FIRST:  out_d = useq_d ? q_sample : i_sample;
				default:       out_d = '0; // Reserved codes pass nothing
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_q    <= '0;
			locked_q <= 1'b0;
			useq_q   <= 1'b0;
		end else if (ce) begin
			out_q    <= out_d;
			locked_q <= locked_d;
			useq_q   <= useq_d;
		end
	end

	assign chan_out     = out_q;
	assign sel_reserved = !(sel inside {RDC_IQ_BOTH, RDC_IQ_I_ONLY, RDC_IQ_Q_ONLY, RDC_IQ_STRONG, RDC_IQ_FIRST});
endmodule : rdc_chan_sel

// ---- hdl/rdc_config.sv ----
// Reader receive signal configuration register and its demodulator
// control. Assumes a classic Wishbone master on clk_sys and a
// demodulator datapath on the same clock.
//
// How it works
// - Bits 23:21 pick both, I only, Q only, strongest or first channel; other codes are reserved.
// - Bit 19, set after reset, enables resync on equal correlation during start of frame.
// - Bit 18 makes every receiver reset also clear the correlator.
// - With phase-shift mode and bit 17 clear the 0110 correlation is filtered by 1110 and 0111.
// - Bit 16 lets data be accepted before the first correlation minimum of the start of frame.
// - Bits 15:12 are the subcarrier detector minimum threshold for phase-shift and Manchester.
// - Bits 11:8 are the phase-shift detector minimum threshold, used only in phase-shift mode.
// - Table entries adjust both thresholds relatively by a sign bit and two magnitude bits.
// - Read-only bit 7 reports the correlator's short evaluation period for Manchester.
// - Bits 6:5 set the collision strength level of 12.5, 25 or 50 percent for Manchester.
// - Bit 0 selects phase-shift demodulation and resets to zero.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module rdc_config
	import rdc_pkg::*;
#(
	parameter int SW = 12, // Sample width
	parameter int CW = 16  // Correlation and strength width
) (
	// Clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [RDC_ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Adaptive table adjust
	input  wire logic                  arc_adj_valid,
	input  wire logic [2:0]            arc_sub_delta,
	input  wire logic [2:0]            arc_phase_delta,
	// Datapath status in
	input  wire logic                  short_eval_window_in,
	input  wire logic                  rx_reset,
	input  wire logic                  frame_start,
	// Samples and correlations
	input  wire logic                  sample_valid,
	input  wire logic [SW-1:0]         i_sample,
	input  wire logic [SW-1:0]         q_sample,
	input  wire logic [CW-1:0]         corr_0110,
	input  wire logic [CW-1:0]         corr_1110,
	input  wire logic [CW-1:0]         corr_0111,
	input  wire logic                  coll_valid,
	input  wire logic [CW-1:0]         coll_strength,
	input  wire logic [CW-1:0]         peak_strength,
	// Controls to the demodulator
	output logic                       psk_mode,
	output logic                       sof_equal_resync_en,
	output logic                       data_accept_early,
	output logic                       correlator_clear,
	output logic      [3:0]            subcarrier_threshold,
	output logic      [3:0]            phase_detect_threshold,
	output logic      [SW-1:0]         chan_sample,
	output logic                       iq_sel_reserved,
	output logic      [CW-1:0]         corr_eff,
	output logic                       collision_flag
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [2:0]    iq_channel_select_q, iq_channel_select_d;
	logic          test_filter_bit_q, test_filter_bit_d;
	logic          resync_q, resync_d;
	logic          correlator_clear_en_q, correlator_clear_en_d;
	logic          pattern_filter_disable_q, pattern_filter_disable_d;
	logic          early_q, early_d;
	logic [3:0]    subth_q, subth_d;
	logic [3:0]    phase_detect_threshold_q, phase_detect_threshold_d;
	logic          short_eval_window_q, short_eval_window_d;
	logic [1:0]    collision_strength_sel_q, collision_strength_sel_d;
	logic          psk_q, psk_d;
	logic          ack_q, ack_d;
	logic [31:0]   dat_q, dat_d;
	logic [31:0]   cfg_word, stat_word, wr_word;
	logic [3:0]    sub_adj, ph_adj;
	logic          wr_cfg;

	// Assemble readback; reserved and test bits read zero
	always_comb begin
		cfg_word = '0;
		cfg_word[RDC_IQ_LSB +: 3]    = iq_channel_select_q;
		cfg_word[RDC_RESYNC_BIT]     = resync_q;
		cfg_word[RDC_CLEAR_BIT]      = correlator_clear_en_q;
		cfg_word[RDC_FILTOFF_BIT]    = pattern_filter_disable_q;
		cfg_word[RDC_EARLY_BIT]      = early_q;
		cfg_word[RDC_SUBTH_LSB +: 4] = subth_q;
		cfg_word[RDC_PHTH_LSB +: 4]  = phase_detect_threshold_q;
		cfg_word[RDC_SHORT_BIT]      = short_eval_window_q;
		cfg_word[RDC_COLL_LSB +: 2]  = collision_strength_sel_q;
		cfg_word[RDC_PSK_BIT]        = psk_q;
		stat_word    = '0;
		stat_word[0] = collision_flag;
		stat_word[1] = iq_sel_reserved;
		stat_word[2] = test_filter_bit_q;
		wr_word      = cfg_word;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				wr_word[b*8 +: 8] = wb_dat_i[b*8 +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave: one wait state, unmapped reads return zero
	// ----------------------------------------------------------------
	always_comb begin
		ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
		wr_cfg = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == RDC_CFG_OFFSET);
		dat_d  = dat_q;
		if (ack_d && !wb_we_i) begin
			unique case (wb_adr_i)
				RDC_CFG_OFFSET:  dat_d = cfg_word;
				RDC_STAT_OFFSET: dat_d = stat_word;
				default:         dat_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else if (ce) begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ----------------------------------------------------------------
	// Threshold adjust by relative table entries
	// ----------------------------------------------------------------
	rdc_thr_adjust u_sub_adj (
		.base   (subth_q),
		.delta  (arc_sub_delta),
		.result (sub_adj)
	);

	rdc_thr_adjust u_ph_adj (
		.base   (phase_detect_threshold_q),
		.delta  (arc_phase_delta),
		.result (ph_adj)
	);

	// Next register values; a software write beats a table adjust
	always_comb begin
		iq_channel_select_d      = iq_channel_select_q;
		test_filter_bit_d        = test_filter_bit_q;
		resync_d                 = resync_q;
		correlator_clear_en_d    = correlator_clear_en_q;
		pattern_filter_disable_d = pattern_filter_disable_q;
		early_d                  = early_q;
		subth_d                  = subth_q;
		phase_detect_threshold_d = phase_detect_threshold_q;
		collision_strength_sel_d = collision_strength_sel_q;
		psk_d                    = psk_q;
		short_eval_window_d      = short_eval_window_window_in_f(short_eval_window_in);
		if (wr_cfg) begin
			iq_channel_select_d      = wr_word[RDC_IQ_LSB +: 3];
			test_filter_bit_d        = 1'b0;
			resync_d                 = wr_word[RDC_RESYNC_BIT];
			correlator_clear_en_d    = wr_word[RDC_CLEAR_BIT];
			pattern_filter_disable_d = wr_word[RDC_FILTOFF_BIT];
			early_d                  = wr_word[RDC_EARLY_BIT];
			subth_d                  = wr_word[RDC_SUBTH_LSB +: 4];
			phase_detect_threshold_d = wr_word[RDC_PHTH_LSB +: 4];
			collision_strength_sel_d = wr_word[RDC_COLL_LSB +: 2];
			psk_d                    = wr_word[RDC_PSK_BIT];
		end else if (arc_adj_valid) begin
			subth_d                  = sub_adj;
			phase_detect_threshold_d = ph_adj;
		end
	end

	// Identity helper keeps the status sample in one place
	function automatic logic short_eval_window_window_in_f(input logic v);
		short_eval_window_window_in_f = v;
	endfunction : short_eval_window_window_in_f

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			iq_channel_select_q      <= RDC_IQ_RST;
			test_filter_bit_q        <= RDC_TEST_RST;
			resync_q                 <= RDC_RESYNC_RST;
			correlator_clear_en_q    <= RDC_CLEAR_RST;
			pattern_filter_disable_q <= RDC_FILTOFF_RST;
			early_q                  <= RDC_EARLY_RST;
			subth_q                  <= RDC_SUBTH_RST;
			phase_detect_threshold_q <= RDC_PHTH_RST;
			short_eval_window_q      <= 1'b0;
			collision_strength_sel_q <= RDC_COLL_RST;
			psk_q                    <= RDC_PSK_RST;
		end else if (ce) begin
			iq_channel_select_q      <= iq_channel_select_d;
			test_filter_bit_q        <= test_filter_bit_d;
			resync_q                 <= resync_d;
			correlator_clear_en_q    <= correlator_clear_en_d;
			pattern_filter_disable_q <= pattern_filter_disable_d;
			early_q                  <= early_d;
			subth_q                  <= subth_d;
			phase_detect_threshold_q <= phase_detect_threshold_d;
			short_eval_window_q      <= short_eval_window_d;
			collision_strength_sel_q <= collision_strength_sel_d;
			psk_q                    <= psk_d;
		end
	end

	// ----------------------------------------------------------------
	// Channel select in phase-shift mode
	// ----------------------------------------------------------------
	rdc_chan_sel #(
		.SW (SW)
	) u_chan (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.ce           (ce),
		.sel          (iq_channel_select_q),
		.first_thr    (subth_q),
		.frame_start  (frame_start),
		.sample_valid (sample_valid && psk_q),
		.i_sample     (i_sample),
		.q_sample     (q_sample),
		.chan_out     (chan_sample),
		.sel_reserved (iq_sel_reserved)
	);

	// ----------------------------------------------------------------
	// Demodulator controls: correlator clear, filter, collision
	// ----------------------------------------------------------------
	logic          clr_q, clr_d;
	logic [CW-1:0] corr_q, corr_d;
	logic          coll_q, coll_d;
	logic [CW+1:0] side_sum;
	logic [CW-1:0] coll_limit;

	always_comb begin
		clr_d    = correlator_clear_en_q && rx_reset;
		side_sum = {{2{corr_1110[CW-1]}}, corr_1110} + {{2{corr_0111[CW-1]}}, corr_0111};
		// Neighbour patterns subtract smeared energy from the centre
		if (psk_q && !pattern_filter_disable_q) begin
			corr_d = CW'({{2{corr_0110[CW-1]}}, corr_0110} - {side_sum[CW+1], side_sum[CW+1:1]});
		end else begin
			corr_d = corr_0110;
		end
		unique case (collision_strength_sel_q)
			RDC_COLL_12P5: coll_limit = peak_strength >> RDC_SHIFT_12P5;
			RDC_COLL_25:   coll_limit = peak_strength >> RDC_SHIFT_25;
			RDC_COLL_50:   coll_limit = peak_strength >> RDC_SHIFT_50;
			RDC_COLL_NONE: coll_limit = '1;
		endcase
		// A report in the clearing cycle still sets the flag
		coll_d = frame_start ? 1'b0 : coll_q;
		if (coll_valid && !psk_q && collision_strength_sel_q != RDC_COLL_NONE && coll_strength > coll_limit) begin
			coll_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clr_q  <= 1'b0;
			corr_q <= '0;
			coll_q <= 1'b0;
		end else if (ce) begin
			clr_q  <= clr_d;
			corr_q <= corr_d;
			coll_q <= coll_d;
		end
	end

	// Plain outputs; phase threshold only matters in phase-shift mode
	assign psk_mode               = psk_q;
	assign sof_equal_resync_en    = resync_q;
	assign data_accept_early      = early_q;
	assign correlator_clear       = clr_q;
	assign subcarrier_threshold   = subth_q;
	assign phase_detect_threshold = psk_q ? phase_detect_threshold_q : 4'h0;
	assign corr_eff               = corr_q;
	assign collision_flag         = coll_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_ACK_PULSE: assert property (ce && ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
	AST_RESERVED_ZERO: assert property (ack_q && !wb_we_i && $past(wb_adr_i) == RDC_CFG_OFFSET
		|-> wb_dat_o[31:24] == 8'h00 && !wb_dat_o[RDC_TEST_BIT])
		else $error("reserved bits read nonzero");
	AST_CLEAR_FOLLOWS: assert property (ce && rx_reset && correlator_clear_en_q |=> correlator_clear)
		else $error("receiver reset did not clear correlator");
	AST_CLEAR_GATED: assert property (ce && !correlator_clear_en_q |=> !correlator_clear)
		else $error("correlator cleared while disabled");
	AST_WRITE_PSK: assert property (ce && wr_cfg |=> psk_mode == $past(wr_word[RDC_PSK_BIT]))
		else $error("psk bit not written");
	AST_WRITE_RESYNC: assert property (ce && wr_cfg |=> sof_equal_resync_en == $past(wr_word[RDC_RESYNC_BIT]))
		else $error("resync bit not written");
	AST_ADJ_RANGE: assert property (ce && arc_adj_valid && !wr_cfg && !arc_sub_delta[2]
		|=> subcarrier_threshold >= $past(subth_q))
		else $error("positive adjust lowered threshold");
	AST_ADJ_STEP: assert property (ce && arc_adj_valid && !wr_cfg && arc_sub_delta[2] && subth_q >= 4'h3
		|=> subcarrier_threshold == $past(subth_q) - $past({2'h0, arc_sub_delta[1:0]}))
		else $error("negative adjust wrong step");
	AST_FILTER_OFF: assert property (ce && pattern_filter_disable_q |=> corr_eff == $past(corr_0110))
		else $error("filter active while disabled");
	AST_EARLY: assert property (ce && wr_cfg |=> data_accept_early == $past(wr_word[RDC_EARLY_BIT]))
		else $error("early accept bit not written");
	AST_COLL_NONE: assert property (collision_strength_sel_q == RDC_COLL_NONE && !collision_flag
		|=> !collision_flag)
		else $error("collision flagged with level off");
	AST_SHORT_EVAL: assert property (ce |=> short_eval_window_q == $past(short_eval_window_in))
		else $error("short evaluation status not captured");
	AST_IQ_WRITE: assert property (ce && wr_cfg |=> iq_channel_select_q == $past(wr_word[RDC_IQ_LSB +: 3]))
		else $error("channel select not written");
	AST_PHTH_WRITE: assert property (ce && wr_cfg |=> phase_detect_threshold_q == $past(wr_word[RDC_PHTH_LSB +: 4]))
		else $error("phase threshold not written");
	AST_SUBTH_WRITE: assert property (ce && wr_cfg |=> subcarrier_threshold == $past(wr_word[RDC_SUBTH_LSB +: 4]))
		else $error("subcarrier threshold not written");
endmodule : rdc_config

// ---- tb/tb_rdc_config.sv ----
// Self-checking bench for the reader receive signal configuration block.
// Assumes the design's classic Wishbone slave on a 25 MHz clk_sys.
`timescale 1ns/1ps
module tb_rdc_config
	import rdc_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus, observation and counters
	// ------------------------------------------------------------
	logic        clk_sys, rstn, ce, cyc, stb, we, arc_v, sew, rx_reset, frame_start, sv, coll_valid;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [2:0]  sub_d, ph_d;
	logic [11:0] i_s, q_s;
	logic [15:0] c0, c1, c2, cs;
	logic [31:0] dw, rd, lf, ecfg;
	wire  [31:0] dat_o;
	wire         ack, psk, rsy, early, cclr, iqr, cflag;
	wire  [3:0]  sth, pth;
	wire  [11:0] chs;
	wire  [15:0] ceff;
	int          n_errors = 0;
	int          n_checks = 0;
	localparam logic [15:0] PEAK = 16'h0320;

	rdc_config rdc_config_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.arc_adj_valid(arc_v), .arc_sub_delta(sub_d), .arc_phase_delta(ph_d), .short_eval_window_in(sew),
		.rx_reset(rx_reset), .frame_start(frame_start), .sample_valid(sv), .i_sample(i_s), .q_sample(q_s),
		.corr_0110(c0), .corr_1110(c1), .corr_0111(c2), .coll_valid(coll_valid), .coll_strength(cs),
		.peak_strength(PEAK), .psk_mode(psk), .sof_equal_resync_en(rsy), .data_accept_early(early),
		.correlator_clear(cclr), .subcarrier_threshold(sth), .phase_detect_threshold(pth),
		.chan_sample(chs), .iq_sel_reserved(iqr), .corr_eff(ceff), .collision_flag(cflag));

	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Random source; a plain shift register keeps the run repeatable
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt

	// Expected control outputs for a given register value
	function automatic logic [31:0] ctl(input logic [31:0] c);
		return {20'h0, c[0], c[19], c[16], c[23:21] inside {3'h3, 3'h6, 3'h7}, c[15:12], c[0] ? c[11:8] : 4'h0};
	endfunction : ctl

	function automatic logic [11:0] mg(input logic [11:0] v);
		return v[11] ? 12'(-v) : v;
	endfunction : mg

	// Expected selected sample with a zero lock threshold
	function automatic logic [11:0] chx(input logic [2:0] m, input logic [11:0] a, input logic [11:0] b);
		logic [12:0] s;
		s = {a[11], a} + {b[11], b};
		case (m)
			3'h0:    return s[12:1];
			3'h1:    return a;
			3'h2:    return b;
			3'h4:    return (mg(b) > mg(a)) ? b : a;
			3'h5:    return (a != 12'h000) ? a : b;
			default: return 12'h000;
		endcase
	endfunction : chx

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; waits for ack under a bound, never a fixed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge clk_sys);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (k >= 20) begin
			n_errors++;
			end_sim();
		end
	endtask : wb

	// Table adjust pulse, then thresholds compared
	task automatic adaptive_receiver_table(input logic [2:0] s, input logic [2:0] p, input logic [7:0] e);
		@(posedge clk_sys);
		arc_v <= 1'b1; sub_d <= s; ph_d <= p;
		@(posedge clk_sys);
		arc_v <= 1'b0;
		#1 chk({24'h0, sth, pth}, {24'h0, e});
	endtask : adaptive_receiver_table

	// Fresh frame, one strength report, sticky flag compared
	task automatic coll(input logic [15:0] s, input logic e);
		@(posedge clk_sys);
		frame_start <= 1'b1;
		@(posedge clk_sys);
		frame_start <= 1'b0; coll_valid <= 1'b1; cs <= s;
		@(posedge clk_sys);
		coll_valid <= 1'b0;
		@(posedge clk_sys);
		#1 chk({31'h0, cflag}, {31'h0, e});
	endtask : coll

	// Fresh frame, one sample pair, selected sample compared
	task automatic smp(input logic [11:0] a, input logic [11:0] b, input logic [11:0] e);
		@(posedge clk_sys);
		frame_start <= 1'b1;
		@(posedge clk_sys);
		frame_start <= 1'b0; sv <= 1'b1; i_s <= a; q_s <= b;
		@(posedge clk_sys);
		sv <= 1'b0;
		#1 chk({20'h0, chs}, {20'h0, e});
	endtask : smp

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{cyc, stb, we, arc_v, sew, rx_reset, frame_start, sv, coll_valid} = '0;
		ce = 1'b1; rstn = 1'b0; adr = 8'h00; sel = 4'hF; dw = 32'h0; sub_d = 3'h0; ph_d = 3'h0;
		i_s = 12'h000; q_s = 12'h000; c0 = 16'h0; c1 = 16'h0; c2 = 16'h0; cs = 16'h0; lf = 32'h16;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		#1 chk({20'h0, psk, rsy, early, iqr, sth, pth}, ctl(32'h0008_0000));
		wb(1'b0, RDC_CFG_OFFSET, 32'h0, rd);
		chk(rd, 32'h0008_0000);
		// Every channel code twice; first write all ones for the reserved bits
		for (int i = 0; i < 16; i++) begin
			lf = (i == 0) ? 32'hFFFF_FFFF : nxt(lf);
			sew <= lf[9]; sv <= lf[3]; i_s <= lf[11:0]; q_s <= lf[27:16];
			ecfg = {lf[31:24], i[2:0], lf[20:0]};
			wb(1'b1, RDC_CFG_OFFSET, ecfg, rd);
			wb(1'b0, RDC_CFG_OFFSET, 32'h0, rd);
			chk(rd, (ecfg & 32'h00EF_FF61) | {24'h0, sew, 7'h0});
			#1 chk({20'h0, psk, rsy, early, iqr, sth, pth}, ctl(ecfg));
		end
		wb(1'b1, 8'h04, 32'hFFFF_FFFF, rd);
		wb(1'b0, 8'h04, 32'h0, rd);
		chk(rd, 32'h0);
		// Each channel code on random and I-silent samples
		for (int m = 0; m < 8; m++) begin
			wb(1'b1, RDC_CFG_OFFSET, {8'h00, m[2:0], 21'h000001}, rd);
			lf = nxt(lf);
			smp(lf[11:0], lf[27:16], chx(m[2:0], lf[11:0], lf[27:16]));
			smp(12'h000, lf[27:16], chx(m[2:0], 12'h000, lf[27:16]));
		end
		wb(1'b1, RDC_CFG_OFFSET, 32'h0000_E201, rd);
		adaptive_receiver_table(3'b011, 3'b111, 8'hF0);
		adaptive_receiver_table(3'b110, 3'b001, 8'hD1);
		// Enable low freezes the thresholds
		ce <= 1'b0;
		adaptive_receiver_table(3'b001, 3'b001, 8'hD1);
		ce <= 1'b1;
		// Correlator clear follows a receiver reset only when enabled
		for (int e = 0; e < 2; e++) begin
			wb(1'b1, RDC_CFG_OFFSET, e[0] ? 32'h0004_0000 : 32'h0, rd);
			@(posedge clk_sys);
			rx_reset <= 1'b1;
			@(posedge clk_sys);
			rx_reset <= 1'b0;
			#1 chk({31'h0, cclr}, {31'h0, e[0]});
			@(posedge clk_sys);
			#1 chk({31'h0, cclr}, 32'h0);
		end
		// Negative neighbour sum exercises the arithmetic shift
		c0 <= 16'h0064; c1 <= 16'hFFD8; c2 <= 16'h0014;
		wb(1'b1, RDC_CFG_OFFSET, 32'h0000_0001, rd);
		repeat (2) @(posedge clk_sys);
		#1 chk({16'h0, ceff}, 32'h006E);
		wb(1'b1, RDC_CFG_OFFSET, 32'h0002_0001, rd);
		repeat (2) @(posedge clk_sys);
		#1 chk({16'h0, ceff}, 32'h0064);
		// Equal strength never flags; one above flags unless level 11
		for (int lv = 0; lv < 4; lv++) begin
			wb(1'b1, RDC_CFG_OFFSET, {25'h0, lv[1:0], 5'h0}, rd);
			coll(PEAK >> (3 - lv), 1'b0);
			coll((PEAK >> (3 - lv)) + 16'h1, lv != 3);
			wb(1'b0, RDC_STAT_OFFSET, 32'h0, rd);
			chk(rd, {31'h0, lv != 3});
		end
		end_sim();
	end
endmodule : tb_rdc_config
